/* rtl/gac_top.sv */
/*
 Alternate function and open-drain configuration for ports A to D, with
 the pad output mux and a filtered pad input.
 Assumes the data direction and output data bits come from the GPIO data
 logic and that peripherals supply their own output value and enable.
*/
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// (R1) Index 02H selects the alternate function sub-register.
// (R2) Enable bit 0: normal GPIO, direction bit rules.
// (R3) Enable bit 1: peripheral controls the pin.
// (R4) Reset: A-C 00H, D 01H, 8-pin A 04H.
// (R5) Index 03H selects the open-drain sub-register.
// (R6) Open-drain bit 1 removes high-level drive.
// (R7) Open-drain acts even under peripheral control.
// (R8) Open-drain bit 0: full push-pull drive.
// (R9) Software enables alternates only where they exist.
// (R10) Per-port registers; index persists until rewritten.
// (R11) Bit n maps pin n; registers read/write.
module gac_top
   import gac_pkg::*;
#(
   parameter bit EIGHT_PIN_VARIANT = 1'b0
) (
   // Clock and reset
   input wire logic MCLK,
   input wire logic RST_B,
   // Register access
   input wire logic [1:0] REG_PORT,
   input wire logic REG_ADDR_WR,
   input wire logic REG_CTL_WR,
   input wire logic REG_ADDR_RD,
   input wire logic REG_CTL_RD,
   input wire logic [7:0] REG_WDATA,
   output logic [7:0] REG_RDATA,
   output logic REG_RVALID,
   // GPIO data logic
   input wire logic [PIN_W-1:0] PIN_DIRECTION,
   input wire logic [PIN_W-1:0] GPIO_OUT_DATA,
   output logic [PIN_W-1:0] PIN_VALUE,
   // Peripherals
   input wire logic [PIN_W-1:0] PERIPH_OUT,
   input wire logic [PIN_W-1:0] PERIPH_OE,
   // Pads
   input wire logic [PIN_W-1:0] PAD_IN,
   output logic [PIN_W-1:0] PAD_OUT,
   output logic [PIN_W-1:0] PAD_OE
);
   logic [NUM_PORTS-1:0][7:0] idx_arr;
   logic [NUM_PORTS-1:0][7:0] af_arr;
   logic [NUM_PORTS-1:0][7:0] oc_arr;
   logic [PIN_W-1:0] af_flat;
   logic [PIN_W-1:0] oc_flat;

   genvar g;
   generate
      for (g = 0; g < NUM_PORTS; g++) begin : port_gen
         localparam logic [7:0] AF_R = (g == int'(PORT_D)) ? AF_RST_D :
            ((g == int'(PORT_A) && EIGHT_PIN_VARIANT) ? AF_RST_A_8PIN : AF_RST_ABC);
         localparam logic [7:0] OC_R = (g == int'(PORT_D)) ? OC_RST_D : OC_RST_ABC;
         gac_cfg_if cfg_i ();
         assign cfg_i.addr_wr = REG_ADDR_WR && REG_PORT == 2'(g);
         assign cfg_i.ctl_wr = REG_CTL_WR && REG_PORT == 2'(g);
         assign cfg_i.wdata = REG_WDATA;
         assign idx_arr[g] = cfg_i.index;
         assign af_arr[g] = cfg_i.af;
         assign oc_arr[g] = cfg_i.oc;
         assign af_flat[g*PORT_W +: PORT_W] = cfg_i.af;
         assign oc_flat[g*PORT_W +: PORT_W] = cfg_i.oc;
         gac_port_bank #(
            .AF_RST(AF_R),
            .OC_RST(OC_R)
         ) u_bank (
            .clk(MCLK),
            .rst_b(RST_B),
            .cfg(cfg_i)
         );
      end
   endgenerate

   // Read-back. Indices other than the two held here belong to other
   // sub-registers, so they read as zero from this block.
   logic [7:0] rdata;
   logic rvalid;
   logic [7:0] next_rdata;
   logic next_rvalid;

   always_comb begin
      next_rdata = RDATA_NONE;
      next_rvalid = REG_ADDR_RD || REG_CTL_RD;
      if (REG_ADDR_RD) begin
         next_rdata = idx_arr[REG_PORT];
      end else if (REG_CTL_RD && idx_arr[REG_PORT] == IDX_ALT_FUNC) begin
         next_rdata = af_arr[REG_PORT]; // R1 R11
      end else if (REG_CTL_RD && idx_arr[REG_PORT] == IDX_OPEN_DRAIN) begin
         next_rdata = oc_arr[REG_PORT]; // R5 R11
      end
   end

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         rdata <= RDATA_NONE;
         rvalid <= 1'b0;
      end else begin
         rdata <= next_rdata;
         rvalid <= next_rvalid;
      end
   end

   assign REG_RDATA = rdata;
   assign REG_RVALID = rvalid;

   // Pad drive. Software must not enable an alternate on a pin with no
   // peripheral behind it; such a pin simply follows the idle peripheral
   // inputs here.
   logic [PIN_W-1:0] pad_out;
   logic [PIN_W-1:0] pad_oe;
   logic [PIN_W-1:0] next_pad_out;
   logic [PIN_W-1:0] next_pad_oe;
   logic [PIN_W-1:0] raw_out;
   logic [PIN_W-1:0] raw_oe;

   always_comb begin
      raw_out = '0;
      raw_oe = '0;
      next_pad_out = '0;
      next_pad_oe = '0;
      for (int i = 0; i < PIN_W; i++) begin
         if (af_flat[i]) begin
            raw_out[i] = PERIPH_OUT[i]; // R3 R9
            raw_oe[i] = PERIPH_OE[i];
         end else begin
            raw_out[i] = GPIO_OUT_DATA[i]; // R2
            raw_oe[i] = !PIN_DIRECTION[i];
         end
         next_pad_out[i] = raw_out[i];
         // The open-drain bit sits after the mux so it binds peripherals too.
         if (oc_flat[i]) begin
            next_pad_oe[i] = raw_oe[i] && !raw_out[i]; // R6 R7
         end else begin
            next_pad_oe[i] = raw_oe[i]; // R8
         end
      end
   end

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         pad_out <= '0;
         pad_oe <= '0;
      end else begin
         pad_out <= next_pad_out;
         pad_oe <= next_pad_oe;
      end
   end

   assign PAD_OUT = pad_out;
   assign PAD_OE = pad_oe;

   // Pad input filter. A level is taken only once two samples agree, which
   // costs four cycles of latency but rejects single-cycle glitches.
   logic [PIN_W-1:0] sync1;
   logic [PIN_W-1:0] sync2;
   logic [PIN_W-1:0] sync3;
   logic [PIN_W-1:0] pin_state;
   logic [PIN_W-1:0] next_pin_state;

   always_comb begin
      next_pin_state = (sync2 & ~(sync2 ^ sync3)) | (pin_state & (sync2 ^ sync3));
   end

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
         pin_state <= '0;
      end else begin
         sync1 <= PAD_IN;
         sync2 <= sync1;
         sync3 <= sync2;
         pin_state <= next_pin_state;
      end
   end

   assign PIN_VALUE = pin_state;

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_B);

   sequence s_ctl_write(logic [7:0] idx);
      REG_CTL_WR && idx_arr[REG_PORT] == idx;
   endsequence

   sequence s_quiet_pad;
      $stable(PAD_IN) [*5];
   endsequence

   a_af_write_lands: assert property (s_ctl_write(IDX_ALT_FUNC) |=> // R1
      af_arr[$past(REG_PORT)] == $past(REG_WDATA))
      else $error("alternate function write lost");
   a_oc_write_lands: assert property (s_ctl_write(IDX_OPEN_DRAIN) |=> // R5
      oc_arr[$past(REG_PORT)] == $past(REG_WDATA))
      else $error("open-drain write lost");
   a_index_persists: assert property (!(REG_ADDR_WR && REG_PORT == PORT_A) |=> // R10
      $stable(idx_arr[0]))
      else $error("port index changed without a write");
   a_reset_values: assert property ($past(RST_B) == 1'b0 |-> // R4
      af_arr[3] == AF_RST_D && oc_arr[3] == OC_RST_D && oc_arr[1] == OC_RST_ABC
      && af_arr[0] == (EIGHT_PIN_VARIANT ? AF_RST_A_8PIN : AF_RST_ABC))
      else $error("wrong reset value");
   a_gpio_direction: assert property (!af_flat[0] && !oc_flat[0] |=> // R2
      PAD_OE[0] == !$past(PIN_DIRECTION[0]) && PAD_OUT[0] == $past(GPIO_OUT_DATA[0]))
      else $error("normal pin not driven by GPIO");
   a_periph_owns: assert property (af_flat[0] && !oc_flat[0] |=> // R3
      PAD_OE[0] == $past(PERIPH_OE[0]) && PAD_OUT[0] == $past(PERIPH_OUT[0]))
      else $error("peripheral not driving its pin");
   a_od_no_high: assert property ((PAD_OE & PAD_OUT & $past(oc_flat)) == '0) // R6
      else $error("open-drain pin driven high");
   a_od_under_af: assert property (af_flat[0] && oc_flat[0] && PERIPH_OUT[0] |=> // R7
      !PAD_OE[0])
      else $error("open-drain ignored under peripheral");
   a_push_pull: assert property (!oc_flat[0] && !af_flat[0] && !PIN_DIRECTION[0] // R8
      && GPIO_OUT_DATA[0] |=> PAD_OE[0] && PAD_OUT[0])
      else $error("push-pull high not driven");
   a_af_readback: assert property (REG_CTL_RD && !REG_ADDR_RD && // R11
      idx_arr[REG_PORT] == IDX_ALT_FUNC |=> REG_RVALID && REG_RDATA == $past(af_arr[REG_PORT]))
      else $error("alternate function read-back wrong");
   a_pin_filter: assert property (s_quiet_pad |=> PIN_VALUE == $past(PAD_IN))
      else $error("filtered pin did not follow steady pad");
endmodule // gac_top
`default_nettype wire

/* common/gac_pkg.sv */
/*
 Constants shared by the port configuration block and its per-port banks.
 Assumes four ports of eight pins each, with sub-registers selected by index.
*/
package gac_pkg;
   localparam int NUM_PORTS = 4;
   localparam int PORT_W = 8;
   localparam int PIN_W = NUM_PORTS * PORT_W;
   localparam logic [1:0] PORT_A = 2'h0;
   localparam logic [1:0] PORT_D = 2'h3;
   // Sub-register indices written to the port address register.
   localparam logic [7:0] IDX_ALT_FUNC = 8'h02;
   localparam logic [7:0] IDX_OPEN_DRAIN = 8'h03;
   // Reset values.
   localparam logic [7:0] INDEX_RST = 8'h00;
   localparam logic [7:0] AF_RST_ABC = 8'h00;
   localparam logic [7:0] AF_RST_D = 8'h01;
   localparam logic [7:0] AF_RST_A_8PIN = 8'h04;
   localparam logic [7:0] OC_RST_ABC = 8'h00;
   localparam logic [7:0] OC_RST_D = 8'h01;
   localparam logic [7:0] RDATA_NONE = 8'h00;
   typedef logic [PORT_W-1:0] gac_byte_t;
endpackage

/* common/gac_cfg_if.sv */
/*
 Carrier between the top module and one port bank.
 Assumes the top drives the strobes and the bank returns its stored state.
*/
`timescale 1ns/100ps
`default_nettype none
interface gac_cfg_if;
   logic addr_wr;
   logic ctl_wr;
   logic [7:0] wdata;
   logic [7:0] index;
   logic [7:0] af;
   logic [7:0] oc;
   modport ctrl (output addr_wr, output ctl_wr, output wdata,
                 input index, input af, input oc);
   modport bank (input addr_wr, input ctl_wr, input wdata,
                 output index, output af, output oc);
endinterface
`default_nettype wire

/* rtl/gac_port_bank.sv */
/*
 One port's address register and its two configuration sub-registers.
 Assumes strobes arrive already decoded for this port, one cycle wide.
*/
`timescale 1ns/100ps
`default_nettype none
module gac_port_bank
   import gac_pkg::*;
#(
   parameter logic [7:0] AF_RST = AF_RST_ABC,
   parameter logic [7:0] OC_RST = OC_RST_ABC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Configuration carrier
   gac_cfg_if.bank cfg
);
   logic [7:0] index;
   logic [7:0] af;
   logic [7:0] oc;
   logic [7:0] next_index;
   logic [7:0] next_af;
   logic [7:0] next_oc;

   always_comb begin
      next_index = index;
      next_af = af;
      next_oc = oc;
      if (cfg.addr_wr) begin
         next_index = cfg.wdata; // R10
      end
      // Each bit lands on the pin of the same number.
      if (cfg.ctl_wr && index == IDX_ALT_FUNC) begin
         next_af = cfg.wdata; // R1 R11
      end
      if (cfg.ctl_wr && index == IDX_OPEN_DRAIN) begin
         next_oc = cfg.wdata; // R5 R11
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         index <= INDEX_RST;
         af <= AF_RST; // R4
         oc <= OC_RST;
      end else begin
         index <= next_index;
         af <= next_af;
         oc <= next_oc;
      end
   end

   assign cfg.index = index;
   assign cfg.af = af;
   assign cfg.oc = oc;
endmodule // gac_port_bank
`default_nettype wire

/* verif/gac_pad_model.sv */
/*
 Board-side model of the pads: a pull-up on every pin and an optional
 external pull to ground.
 Assumes the bench commands the external pulls.
*/
`timescale 1ns/100ps
`default_nettype none
module gac_pad_model
   import gac_pkg::*;
(
   // Pad drive from the block
   input wire logic [PIN_W-1:0] pad_out,
   input wire logic [PIN_W-1:0] pad_oe,
   // Board side
   input wire logic [PIN_W-1:0] ext_low,
   output logic [PIN_W-1:0] pad_level
);
   // A released pin floats to the pull-up level unless the board pulls it low.
   assign pad_level = (pad_oe & pad_out) | (~pad_oe & ~ext_low);
endmodule // gac_pad_model
`default_nettype wire

/* verif/tb.sv */
/*
 Self-checking bench for the port configuration block.
 Assumes the pad model stands at the pads and the bench plays the CPU.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
   import gac_pkg::*;
   logic mclk;
   logic rst_b;
   logic [1:0] port;
   logic awr, cwr, ard, crd;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic [7:0] rdata8;
   logic rvalid;
   logic [PIN_W-1:0] dir, gout, pval, pout, poe, pin, pad_out, pad_oe, ext_low;
   int mismatches;
   int checked;
   logic [7:0] v;

   gac_top i_gac_top (.MCLK(mclk), .RST_B(rst_b), .REG_PORT(port), .REG_ADDR_WR(awr),
      .REG_CTL_WR(cwr), .REG_ADDR_RD(ard), .REG_CTL_RD(crd), .REG_WDATA(wdata),
      .REG_RDATA(rdata), .REG_RVALID(rvalid), .PIN_DIRECTION(dir), .GPIO_OUT_DATA(gout),
      .PIN_VALUE(pval), .PERIPH_OUT(pout), .PERIPH_OE(poe), .PAD_IN(pin),
      .PAD_OUT(pad_out), .PAD_OE(pad_oe));
   // A second copy in the small-package variant only differs in its port A reset.
   gac_top #(.EIGHT_PIN_VARIANT(1'b1)) i_gac_top_8pin (.MCLK(mclk), .RST_B(rst_b),
      .REG_PORT(port), .REG_ADDR_WR(awr), .REG_CTL_WR(cwr), .REG_ADDR_RD(ard),
      .REG_CTL_RD(crd), .REG_WDATA(wdata), .REG_RDATA(rdata8), .REG_RVALID(),
      .PIN_DIRECTION(dir), .GPIO_OUT_DATA(gout), .PIN_VALUE(), .PERIPH_OUT(pout),
      .PERIPH_OE(poe), .PAD_IN(pin), .PAD_OUT(), .PAD_OE());
   gac_pad_model i_gac_pad_model (.pad_out(pad_out), .pad_oe(pad_oe), .ext_low(ext_low),
      .pad_level(pin));

   always #50 mclk = ~mclk;

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [1:0] p, input logic [7:0] idx, input logic [7:0] d);
      @(posedge mclk);
      port <= p;
      awr <= 1'b1;
      wdata <= idx;
      @(posedge mclk);
      awr <= 1'b0;
      cwr <= 1'b1;
      wdata <= d;
      @(posedge mclk);
      cwr <= 1'b0;
   endtask

   task automatic rd(input logic [1:0] p, input logic [7:0] idx, output logic [7:0] d);
      @(posedge mclk);
      port <= p;
      awr <= 1'b1;
      wdata <= idx;
      @(posedge mclk);
      awr <= 1'b0;
      crd <= 1'b1;
      @(posedge mclk);
      crd <= 1'b0;
      @(negedge mclk);
      chk("read valid", 32'h1, {31'h0, rvalid});
      d = rdata;
   endtask

   task automatic t_reset();
      for (int p = 0; p < 4; p++) begin
         rd(p[1:0], IDX_ALT_FUNC, v);
         chk("af reset", (p == 3) ? 8'h01 : 8'h00, v);
         chk("af reset 8-pin", (p == 3) ? 8'h01 : ((p == 0) ? 8'h04 : 8'h00), rdata8);
         rd(p[1:0], IDX_OPEN_DRAIN, v);
         chk("oc reset", (p == 3) ? 8'h01 : 8'h00, v);
      end
      $display("test reset done");
   endtask

   task automatic t_pin();
      @(posedge mclk);
      ext_low <= 32'h0000_ff00;
      repeat (4) @(negedge mclk);
      chk("pin early", 32'hffff_ffff, pval);
      @(negedge mclk);
      chk("pin level", 32'hffff_00ff, pval);
      @(posedge mclk);
      ext_low <= 32'hffff_00ff;
      @(posedge mclk);
      ext_low <= 32'h0000_ff00;
      // The one-cycle glitch must never reach the filtered level.
      repeat (6) begin
         @(negedge mclk);
         chk("pin glitch", 32'hffff_00ff, pval);
      end
      $display("test pin input done");
   endtask

   task automatic t_regs();
      for (int p = 0; p < 4; p++) begin
         wr(p[1:0], IDX_ALT_FUNC, 8'ha0 | 8'(p));
         wr(p[1:0], IDX_OPEN_DRAIN, 8'h50 | 8'(p));
      end
      for (int p = 0; p < 4; p++) begin
         rd(p[1:0], IDX_ALT_FUNC, v);
         chk("af value", 8'ha0 | 8'(p), v);
         rd(p[1:0], IDX_OPEN_DRAIN, v);
         chk("oc value", 8'h50 | 8'(p), v);
      end
      wr(2'h0, 8'h05, 8'hff);
      rd(2'h0, 8'h05, v);
      chk("unmapped", 32'h0, v);
      @(posedge mclk);
      ard <= 1'b1;
      @(posedge mclk);
      ard <= 1'b0;
      @(negedge mclk);
      chk("index", 32'h05, rdata);
      rd(2'h0, IDX_ALT_FUNC, v);
      chk("af kept", 32'ha0, v);
      @(posedge mclk);
      crd <= 1'b1;
      @(posedge mclk);
      crd <= 1'b0;
      @(negedge mclk);
      chk("index persists", 32'ha0, rdata);
      $display("test registers done");
   endtask

   task automatic t_mux(input logic [7:0] oc);
      logic [31:0] af32, out, oe;
      for (int p = 0; p < 4; p++) begin
         wr(p[1:0], IDX_ALT_FUNC, 8'h3c);
         wr(p[1:0], IDX_OPEN_DRAIN, oc);
      end
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      af32 = {4{8'h3c}};
      out = (af32 & pout) | (~af32 & gout);
      oe = ((af32 & poe) | (~af32 & ~dir)) & ~({4{oc}} & out);
      chk("pad out", out, pad_out);
      chk("pad oe", oe, pad_oe);
      $display("test pad mux done");
   endtask

   task automatic complete_run();
      $display("counts: checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      mclk = 1'b0;
      rst_b = 1'b0;
      {port, awr, cwr, ard, crd, wdata} = '0;
      // Every pin an input with no peripheral drive, so the pull-ups set levels.
      dir = '1;
      gout = 32'ha5a5_5a5a;
      pout = 32'h3333_cccc;
      poe = '0;
      ext_low = '0;
      mismatches = 0;
      checked = 0;
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      t_reset();
      t_pin();
      t_regs();
      // Alternates go on pins 2 to 5 of every port, including pins where the peripheral enable is low.
      @(posedge mclk);
      dir <= 32'h0f0f_0f0f;
      poe <= 32'hf0f0_55aa;
      t_mux(8'h00);
      t_mux(8'hff);
      t_mux(8'h0f);
      complete_run();
   end

   initial begin
      #300000;
      mismatches++;
      complete_run();
   end
endmodule // tb
`default_nettype wire
